// *** src/power_mode_pkg.sv ***
// Constants, types and state record for the power-mode and regulator controller.
// Assumes a byte-wide special-function register bus driven by the CPU core.
package power_mode_pkg;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_REGULATOR_CONTROL = 8'hC9;
   localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
   localparam logic [7:0] ADDR_OSC_SUSPEND = 8'hB6;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int PRIMARY_DISABLE_BIT = 7;
   localparam int WAKE_LEVEL_BIT = 6;
   localparam int PRIMARY_LOW_POWER_BIT = 4;
   localparam int STOP_SHUTDOWN_BIT = 3;
   localparam int CORE_LOW_POWER_BIT = 1;
   localparam int IDLE_SELECT_BIT = 0;
   localparam int STOP_SELECT_BIT = 1;
   localparam int FLAGS_LSB = 2;
   localparam int SUSPEND_BIT = 5;

   // ----------------------------------------------------------------
   // Reset values and masks
   // ----------------------------------------------------------------
   localparam logic [7:0] REGULATOR_CONTROL_RESET = 8'h00;
   localparam logic [5:0] FLAGS_RESET = 6'h00;
   localparam logic [7:0] REGULATOR_WRITE_MASK = 8'hBF;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   localparam logic [15:0] RESET_VECTOR = 16'h0000;

   // ----------------------------------------------------------------
   // Modes and state record
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      MODE_RUN = 4'b0001,
      MODE_IDLE = 4'b0010,
      MODE_STOP = 4'b0100,
      MODE_SUSPEND = 4'b1000
   } pm_mode_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } sfr_req_t;

   typedef struct packed {
      pm_mode_t mode;
      logic [7:0] regulator_control;
      logic [5:0] flags;
      logic idle_armed;
      logic stop_armed;
      logic suspend_armed;
      logic core_shutdown;
      logic cpu_halt;
      logic osc_stop;
      logic hf_osc_suspend;
      logic wake_level;
      logic wake_prev;
      logic wake_edge;
      logic resume;
      logic reset_request;
      logic [15:0] restart_addr;
      logic [7:0] rdata;
   } pm_state_t;

endpackage

// *** src/power_mode_regulator_control.sv ***
// Power-mode sequencer and regulator control register for an 8-bit core.
// Assumes the CPU core drives the SFR bus in core_clk_i, pulses instr_done_i
// when each instruction completes, and acts on the halt and reset outputs.
//
// Contract
// - Control register at 0xC9, clears on reset
// - Bit 7 disables primary regulator
// - Bit 6 reads live wake pin level
// - Bit 4 puts primary regulator low-power
// - Bit 3 shuts core regulator in stop
// - Bit 1 puts core regulator low-power
// - Idle halts CPU after setting instruction
// - Enabled interrupt ends idle, resumes CPU
// - Reset from low power restarts at zero
// - Enabled watchdog timeout ends idle by reset
// - Stop halts oscillator, CPU, digital peripherals
// - Only reset leaves stop, never interrupts
// - Enabled missing-clock detector resets out of stop unless bit 3 shut the core regulator
// - Suspend halts fast oscillator, CPU may run
// - Wake pin edge or reset ends suspend
// - Fast-oscillator wake continues, services wake interrupt
// - Wake interrupt on both edges, no flag
// - Idle and stop select read zero
`timescale 1ns/1ps

module power_mode_regulator_control
   import power_mode_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   output logic [7:0] sfr_rdata_o,
   input wire logic instr_done_i,
   input wire logic irq_pending_i,
   input wire logic wake_pin_i,
   input wire logic hf_osc_selected_i,
   input wire logic reset_pin_i,
   input wire logic internal_reset_i,
   input wire logic watchdog_enable_i,
   input wire logic watchdog_timeout_i,
   input wire logic missing_clock_enable_i,
   input wire logic missing_clock_timeout_i,
   output logic primary_regulator_disable_o,
   output logic primary_regulator_low_power_o,
   output logic core_regulator_low_power_o,
   output logic core_regulator_shutdown_o,
   output logic cpu_halt_o,
   output logic int_osc_stop_o,
   output logic hf_osc_suspend_o,
   output logic wake_irq_o,
   output logic cpu_resume_o,
   output logic device_reset_o,
   output logic [15:0] restart_addr_o,
   output logic [3:0] power_mode_o
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // No page input: the block answers on every register page.
   function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] target);
      sfr_hit = (addr == target);
   endfunction

   pm_state_t st_q;
   pm_state_t st_d;
   sfr_req_t req;
   logic wr_ctrl;
   logic wr_power;
   logic wr_suspend;
   logic idle_go;
   logic stop_go;
   logic suspend_go;
   logic reset_go;

   assign req.addr = sfr_addr_i;
   assign req.wdata = sfr_wdata_i;
   assign req.wr = sfr_wr_i;
   assign req.rd = sfr_rd_i;

   assign wr_ctrl = req.wr && sfr_hit(req.addr, ADDR_REGULATOR_CONTROL);
   assign wr_power = req.wr && sfr_hit(req.addr, ADDR_POWER_CONTROL);
   assign wr_suspend = req.wr && sfr_hit(req.addr, ADDR_OSC_SUSPEND);

   // ----------------------------------------------------------------
   // Reset source qualification
   // ----------------------------------------------------------------
   // With the core regulator shut down the internal network is dead, so
   // only the pin can bring the device back.
   always_comb begin
      reset_go = reset_pin_i;
      case (st_q.mode)
         MODE_STOP: begin
            if (!st_q.core_shutdown) begin
               reset_go = reset_go || internal_reset_i;
               reset_go = reset_go || (missing_clock_enable_i && missing_clock_timeout_i);
            end
         end
         MODE_IDLE: begin
            reset_go = reset_go || internal_reset_i;
            reset_go = reset_go || (watchdog_enable_i && watchdog_timeout_i);
            reset_go = reset_go || (missing_clock_enable_i && missing_clock_timeout_i);
         end
         default: begin
            reset_go = reset_go || internal_reset_i;
            reset_go = reset_go || (watchdog_enable_i && watchdog_timeout_i);
            reset_go = reset_go || (missing_clock_enable_i && missing_clock_timeout_i);
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Entry requests
   // ----------------------------------------------------------------
   // A select written in the same cycle as the completion strobe counts,
   // so a one-cycle store instruction is not missed.
   always_comb begin
      stop_go = instr_done_i
         && (st_q.stop_armed || (wr_power && req.wdata[STOP_SELECT_BIT]));
      idle_go = instr_done_i && !stop_go
         && (st_q.idle_armed || (wr_power && req.wdata[IDLE_SELECT_BIT]));
      suspend_go = instr_done_i && !stop_go && !idle_go
         && (st_q.suspend_armed || (wr_suspend && req.wdata[SUSPEND_BIT]));
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.wake_edge = 1'b0;
      st_d.resume = 1'b0;
      st_d.reset_request = 1'b0;

      // Pin level sampled once; the edge compares two registered samples.
      st_d.wake_level = wake_pin_i;
      st_d.wake_prev = st_q.wake_level;
      st_d.wake_edge = st_q.wake_level ^ st_q.wake_prev;

      // Register writes
      if (wr_ctrl) begin
         // Reserved bits are kept as written but drive nothing.
         st_d.regulator_control = req.wdata & REGULATOR_WRITE_MASK;
      end
      if (wr_power) begin
         st_d.flags = req.wdata[7:FLAGS_LSB];
         if (req.wdata[STOP_SELECT_BIT]) begin
            st_d.stop_armed = 1'b1;
         end
         if (req.wdata[IDLE_SELECT_BIT]) begin
            st_d.idle_armed = 1'b1;
         end
      end
      if (wr_suspend && req.wdata[SUSPEND_BIT]) begin
         st_d.suspend_armed = 1'b1;
      end

      // Mode sequencing
      case (st_q.mode)
         MODE_RUN: begin
            if (stop_go) begin
               st_d.mode = MODE_STOP;
               st_d.stop_armed = 1'b0;
               st_d.idle_armed = 1'b0;
               // Shutdown choice is frozen at entry; later writes cannot land.
               st_d.core_shutdown = st_q.regulator_control[STOP_SHUTDOWN_BIT];
            end else if (idle_go) begin
               st_d.mode = MODE_IDLE;
               st_d.idle_armed = 1'b0;
            end else if (suspend_go) begin
               st_d.mode = MODE_SUSPEND;
               st_d.suspend_armed = 1'b0;
            end
         end
         MODE_IDLE: begin
            if (irq_pending_i) begin
               st_d.mode = MODE_RUN;
               st_d.resume = 1'b1;
            end
         end
         MODE_STOP: begin
            // Interrupts are ignored here; only the reset path below exits.
            st_d.mode = MODE_STOP;
         end
         MODE_SUSPEND: begin
            if (st_q.wake_edge) begin
               st_d.mode = MODE_RUN;
               st_d.resume = hf_osc_selected_i;
            end else if (stop_go) begin
               st_d.mode = MODE_STOP;
               st_d.stop_armed = 1'b0;
               st_d.idle_armed = 1'b0;
               st_d.core_shutdown = st_q.regulator_control[STOP_SHUTDOWN_BIT];
            end else if (idle_go) begin
               st_d.mode = MODE_IDLE;
               st_d.idle_armed = 1'b0;
            end
         end
         default: begin
            st_d.mode = MODE_RUN;
         end
      endcase

      // A qualified reset overrides every mode and drops pending entries.
      if (reset_go) begin
         st_d.mode = MODE_RUN;
         st_d.reset_request = 1'b1;
         st_d.restart_addr = RESET_VECTOR;
         st_d.idle_armed = 1'b0;
         st_d.stop_armed = 1'b0;
         st_d.suspend_armed = 1'b0;
         st_d.resume = 1'b0;
      end

      // Derived mode outputs, registered alongside the mode itself
      st_d.cpu_halt = (st_d.mode == MODE_IDLE) || (st_d.mode == MODE_STOP);
      st_d.osc_stop = (st_d.mode == MODE_STOP);
      st_d.hf_osc_suspend = (st_d.mode == MODE_SUSPEND)
         || (st_d.mode == MODE_STOP);
      if (st_d.mode != MODE_STOP) begin
         st_d.core_shutdown = 1'b0;
      end

      // Read data, one cycle after the strobe
      st_d.rdata = READ_UNMAPPED;
      if (req.rd) begin
         if (sfr_hit(req.addr, ADDR_REGULATOR_CONTROL)) begin
            st_d.rdata = st_q.regulator_control;
            st_d.rdata[WAKE_LEVEL_BIT] = st_q.wake_level;
         end else if (sfr_hit(req.addr, ADDR_POWER_CONTROL)) begin
            // Select bits are write-only triggers.
            st_d.rdata = {st_q.flags, 2'b00};
         end else if (sfr_hit(req.addr, ADDR_OSC_SUSPEND)) begin
            st_d.rdata[SUSPEND_BIT] = (st_q.mode == MODE_SUSPEND);
         end
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         st_q.mode <= MODE_RUN;
         st_q.regulator_control <= REGULATOR_CONTROL_RESET;
         st_q.flags <= FLAGS_RESET;
         st_q.idle_armed <= 1'b0;
         st_q.stop_armed <= 1'b0;
         st_q.suspend_armed <= 1'b0;
         st_q.core_shutdown <= 1'b0;
         st_q.cpu_halt <= 1'b0;
         st_q.osc_stop <= 1'b0;
         st_q.hf_osc_suspend <= 1'b0;
         st_q.wake_level <= 1'b0;
         st_q.wake_prev <= 1'b0;
         st_q.wake_edge <= 1'b0;
         st_q.resume <= 1'b0;
         st_q.reset_request <= 1'b0;
         st_q.restart_addr <= RESET_VECTOR;
         st_q.rdata <= READ_UNMAPPED;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Regulator disable and low-power controls follow the stored bits directly; software keeps
   // the core low-power bit clear while the primary regulator is off.
   assign primary_regulator_disable_o = st_q.regulator_control[PRIMARY_DISABLE_BIT];
   assign primary_regulator_low_power_o = st_q.regulator_control[PRIMARY_LOW_POWER_BIT];
   assign core_regulator_low_power_o = st_q.regulator_control[CORE_LOW_POWER_BIT];
   assign core_regulator_shutdown_o = st_q.core_shutdown;
   assign cpu_halt_o = st_q.cpu_halt;
   assign int_osc_stop_o = st_q.osc_stop;
   assign hf_osc_suspend_o = st_q.hf_osc_suspend;
   assign wake_irq_o = st_q.wake_edge;
   assign cpu_resume_o = st_q.resume;
   assign device_reset_o = st_q.reset_request;
   assign restart_addr_o = st_q.restart_addr;
   assign power_mode_o = st_q.mode;
   assign sfr_rdata_o = st_q.rdata;

endmodule

// *** bench/cpu_core_model.sv ***
// CPU core stand-in that retires one instruction every four clocks.
// Assumes the sequencer under test drives cpu_halt_i high in idle and stop.
`timescale 1ns/1ps
module cpu_core_model (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic cpu_halt_i,
   output logic instr_done_o
);
   logic [1:0] count_q;
   // ------------------------------------------------------------
   // Four-clock instructions stand for multi-byte opcodes
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (reset_i || cpu_halt_i) begin
         count_q <= 2'h0;
      end else begin
         count_q <= count_q + 2'h1;
      end
   end
   assign instr_done_o = (count_q == 2'h3) && !cpu_halt_i;
endmodule

// *** bench/power_mode_regulator_control_props.sv ***
// Port-level checks of the power-mode sequencer.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
module power_mode_checker
   import power_mode_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic irq_pending_i,
   input wire logic wake_pin_i,
   input wire logic reset_pin_i,
   input wire logic cpu_halt_o,
   input wire logic int_osc_stop_o,
   input wire logic hf_osc_suspend_o,
   input wire logic wake_irq_o,
   input wire logic cpu_resume_o,
   input wire logic device_reset_o,
   input wire logic [15:0] restart_addr_o,
   input wire logic [3:0] power_mode_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   select_read_zero_a: assert property (sfr_rd_i && sfr_addr_i == ADDR_POWER_CONTROL
      |=> sfr_rdata_o[1:0] == 2'h0) else $error("select bits read nonzero");
   wake_level_a: assert property (sfr_rd_i && sfr_addr_i == ADDR_REGULATOR_CONTROL
      && !$past(reset_i) |=> sfr_rdata_o[6] == $past(wake_pin_i, 2)) else $error("wake level");
   halt_mode_a: assert property (cpu_halt_o == (power_mode_o == MODE_IDLE
      || power_mode_o == MODE_STOP)) else $error("halt does not match mode");
   idle_wake_a: assert property (power_mode_o == MODE_IDLE && irq_pending_i
      |=> power_mode_o == MODE_RUN && (cpu_resume_o || device_reset_o)) else $error("idle exit");
   stop_outputs_a: assert property (power_mode_o == MODE_STOP
      |-> int_osc_stop_o && hf_osc_suspend_o) else $error("stop outputs");
   stop_no_irq_a: assert property (power_mode_o == MODE_STOP |=> !cpu_resume_o)
      else $error("resume out of stop");
   stop_pin_reset_a: assert property (power_mode_o == MODE_STOP && reset_pin_i
      |=> device_reset_o && power_mode_o == MODE_RUN) else $error("pin reset in stop");
   restart_zero_a: assert property (device_reset_o |-> restart_addr_o == 16'h0000
      && power_mode_o == MODE_RUN) else $error("restart address");
   wake_edge_a: assert property (wake_pin_i != $past(wake_pin_i) |-> ##2 wake_irq_o)
      else $error("wake edge missed");
   suspend_wake_a: assert property (power_mode_o == MODE_SUSPEND && wake_irq_o
      |=> power_mode_o == MODE_RUN) else $error("suspend exit");
endmodule
bind power_mode_regulator_control power_mode_checker power_mode_checker_i (.*);

// *** bench/power_mode_regulator_control_test.sv ***
// Self-checking bench for the power-mode sequencer and regulator register.
// Assumes the CPU stand-in model supplies instruction completions.
`timescale 1ns/1ps
module power_mode_regulator_control_test;
   import power_mode_pkg::*;
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
   logic sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, irq_pending_i = 1'b0, wake_pin_i = 1'b0;
   logic hf_osc_selected_i = 1'b0, reset_pin_i = 1'b0, internal_reset_i = 1'b0;
   logic watchdog_enable_i = 1'b0, watchdog_timeout_i = 1'b0;
   logic missing_clock_enable_i = 1'b0, missing_clock_timeout_i = 1'b0;
   logic instr_done_i, primary_regulator_disable_o, primary_regulator_low_power_o;
   logic core_regulator_low_power_o, core_regulator_shutdown_o, cpu_halt_o, int_osc_stop_o;
   logic hf_osc_suspend_o, wake_irq_o, cpu_resume_o, device_reset_o;
   logic [15:0] restart_addr_o;
   logic [3:0] power_mode_o;
   int n_mismatch = 0;
   int tests_run = 0;
   power_mode_regulator_control power_mode_regulator_control_i (.*);
   cpu_core_model cpu_core_model_i (.core_clk_i(core_clk_i), .reset_i(reset_i),
      .cpu_halt_i(cpu_halt_o), .instr_done_o(instr_done_i));
   initial forever #12.5 core_clk_i = ~core_clk_i;
   // ------------------------------------------------------------
   // Bus and compare helpers
   // ------------------------------------------------------------
   task automatic tick(int n = 1);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      tick();
      sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_wr_i = 1'b1;
      tick();
      sfr_wr_i = 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] exp, string what);
      tick();
      sfr_addr_i = a;
      sfr_rd_i = 1'b1;
      tick();
      sfr_rd_i = 1'b0;
      chk(what, {8'h00, exp}, {8'h00, sfr_rdata_o});
   endtask
   // Bounded wait, so a stuck sequencer shows as a mismatch, not a hang
   task automatic wait_mode(pm_mode_t m, string what);
      for (int i = 0; i < 60 && power_mode_o !== m; i++) tick();
      chk(what, {12'h000, m}, {12'h000, power_mode_o});
      $display("Test %s done", what);
   endtask
   task automatic test_done();
      $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #100us;
      n_mismatch++;
      test_done();
   end
   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      tick(2);
      reset_i = 1'b0;
      rd(ADDR_REGULATOR_CONTROL, 8'h00, "reg_reset");
      rd(8'h55, 8'h00, "unmapped");
      wr(ADDR_REGULATOR_CONTROL, 8'hD8);
      rd(ADDR_REGULATOR_CONTROL, 8'h98, "reg_bits");
      chk("reg_outs", 16'h0006, {13'h0, primary_regulator_disable_o,
         primary_regulator_low_power_o, core_regulator_low_power_o});
      wake_pin_i = 1'b1;
      tick(2);
      rd(ADDR_REGULATOR_CONTROL, 8'hD8, "wake_level");
      wr(ADDR_REGULATOR_CONTROL, 8'h0A);
      wr(ADDR_POWER_CONTROL, 8'hFD);
      wait_mode(MODE_IDLE, "idle_entry");
      rd(ADDR_POWER_CONTROL, 8'hFC, "flags");
      irq_pending_i = 1'b1;
      wait_mode(MODE_RUN, "idle_irq");
      irq_pending_i = 1'b0;
      wr(ADDR_POWER_CONTROL, 8'h01);
      wait_mode(MODE_IDLE, "idle_again");
      watchdog_enable_i = 1'b1;
      watchdog_timeout_i = 1'b1;
      tick();
      watchdog_timeout_i = 1'b0;
      wait_mode(MODE_RUN, "idle_watchdog");
      chk("restart", 16'h0000, restart_addr_o);
      wr(ADDR_POWER_CONTROL, 8'h02);
      wait_mode(MODE_STOP, "stop_entry");
      chk("stop_outs", 16'h0007, {13'h0, core_regulator_shutdown_o,
         int_osc_stop_o, cpu_halt_o});
      irq_pending_i = 1'b1;
      internal_reset_i = 1'b1;
      tick(8);
      chk("stop_hold", {12'h000, MODE_STOP}, {12'h000, power_mode_o});
      irq_pending_i = 1'b0;
      internal_reset_i = 1'b0;
      reset_pin_i = 1'b1;
      tick();
      reset_pin_i = 1'b0;
      wait_mode(MODE_RUN, "stop_pin");
      wr(ADDR_REGULATOR_CONTROL, 8'h00);
      wr(ADDR_POWER_CONTROL, 8'h02);
      wait_mode(MODE_STOP, "stop_plain");
      chk("no_shutdown", 16'h0000, {15'h0, core_regulator_shutdown_o});
      missing_clock_enable_i = 1'b1;
      missing_clock_timeout_i = 1'b1;
      tick();
      missing_clock_timeout_i = 1'b0;
      wait_mode(MODE_RUN, "stop_mcd");
      wr(ADDR_REGULATOR_CONTROL, 8'h02);
      tick(60);
      hf_osc_selected_i = 1'b1;
      for (int k = 0; k < 2; k++) begin
         wr(ADDR_OSC_SUSPEND, 8'h20);
         wait_mode(MODE_SUSPEND, "suspend_entry");
         chk("hf_suspend", 16'h0001, {15'h0, hf_osc_suspend_o});
         wake_pin_i = ~wake_pin_i;
         wait_mode(MODE_RUN, "suspend_wake");
      end
      reset_i = 1'b1;
      tick(2);
      reset_i = 1'b0;
      // Stored bits cleared; bit 6 still follows the pin, which is high here
      rd(ADDR_REGULATOR_CONTROL, 8'h40, "reg_rereset");
      test_done();
   end
endmodule
